// File: pnpp_buf2.sv
`timescale 1ns/100ps
module pnpp_buf2 import pnpp_pkg::*; #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];

    always_comb begin
        mem_nxt = mem_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
        end
        wr_nxt = push ? ~wr_r : wr_r;
        rd_nxt = pop ? ~rd_r : rd_r;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            cnt_r <= 2'h0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
        end
    end
endmodule

// File: pnpp_pkg.sv
package pnpp_pkg;
    localparam logic [1:0] PNPP_LD_ADDR = 2'h0;
    localparam logic [1:0] PNPP_LD_DATA = 2'h1;
    localparam logic [1:0] PNPP_LD_CMD = 2'h2;
    localparam logic [7:0] PNPP_CMD_NOP = 8'h00;
    localparam logic [7:0] PNPP_CMD_ERASE = 8'h80;
    localparam logic [7:0] PNPP_CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] PNPP_CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] PNPP_CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] PNPP_CMD_WR_EE = 8'h11;
    localparam logic [7:0] PNPP_CMD_RD_SIG = 8'h08;
    localparam logic [7:0] PNPP_CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] PNPP_CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] PNPP_CMD_RD_EE = 8'h03;
    localparam logic [7:0] PNPP_ERASED = 8'hFF;
    localparam logic [7:0] PNPP_SIG_MAX = 8'h02;
    localparam logic [7:0] PNPP_CAL_ADDR = 8'h00;
    localparam int PNPP_CLK_MHZ = 100;
    localparam int PNPP_WLRL_NS = 1000;
    localparam int PNPP_WLRL_CYC = PNPP_WLRL_NS * PNPP_CLK_MHZ / 1000;
    localparam int PNPP_PROG_US = 4000;
    localparam int PNPP_PROG_CYC = PNPP_PROG_US * PNPP_CLK_MHZ;
    localparam int PNPP_ERASE_US = 8000;
    localparam int PNPP_ERASE_CYC = PNPP_ERASE_US * PNPP_CLK_MHZ;
    localparam int PNPP_FLASH_WORDS = 4096;
    localparam int PNPP_PAGE_WORDS = 32;
    localparam int PNPP_EE_BYTES = 512;
    localparam int PNPP_EE_PAGE = 4;
    localparam logic [7:0] PNPP_LOCK_BOOT_MASK = 8'h3C;
    localparam logic [1:0] PNPP_SEL_LFUSE = 2'h0;
    localparam logic [1:0] PNPP_SEL_LOCK = 2'h1;
    localparam logic [1:0] PNPP_SEL_EFUSE = 2'h2;
    localparam logic [1:0] PNPP_SEL_HFUSE = 2'h3;
    typedef enum logic [1:0] {PNPP_IDLE, PNPP_ACK, PNPP_BUSY} pnpp_state_e;
endpackage

// File: pnpp_port.sv
`timescale 1ns/100ps
module pnpp_port import pnpp_pkg::*; #(
    parameter int PROG_CYC = PNPP_PROG_CYC,
    parameter int ERASE_CYC = PNPP_ERASE_CYC,
    parameter int FLASH_WORDS = PNPP_FLASH_WORDS,
    parameter int PAGE_WORDS = PNPP_PAGE_WORDS,
    parameter int EE_BYTES = PNPP_EE_BYTES,
    parameter int EE_PAGE = PNPP_EE_PAGE,
    parameter logic [7:0] SIG0 = 8'hC4,
    parameter logic [7:0] SIG1 = 8'h5A,
    parameter logic [7:0] SIG2 = 8'hA5,
    parameter logic [7:0] CAL_BYTE = 8'h80,
    parameter logic [7:0] LFUSE_RST = 8'hFF,
    parameter logic [7:0] HFUSE_RST = 8'hFF,
    parameter logic [7:0] EFUSE_RST = 8'hFF
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic CRYSTAL_INPUT_STROBE,
    input wire logic LOAD_SELECT_HI,
    input wire logic LOAD_SELECT_LO,
    input wire logic BYTE_SELECT_ONE,
    input wire logic BYTE_SELECT_TWO,
    input wire logic PAGE_LOAD_STROBE,
    input wire logic WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic [7:0] DATA_I,
    output logic [7:0] DATA_O,
    output logic [7:0] DATA_OE_N,
    output logic READY_BUSY_PIN
);
    // Signature and calibration defaults above are arbitrary values.
    localparam int FAW = $clog2(FLASH_WORDS);
    localparam int PWW = $clog2(PAGE_WORDS);
    localparam int EAW = $clog2(EE_BYTES);
    localparam int EPW = $clog2(EE_PAGE);
    localparam int CW = $clog2(ERASE_CYC + 1);
    localparam logic [CW-1:0] PROG_LEN = CW'(PROG_CYC);
    localparam logic [CW-1:0] ERASE_LEN = CW'(ERASE_CYC);

    ////////////////////////////////////////////////////////////////////////////
    logic rst_a_r, rst_b_r, rst_n;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end
    assign rst_n = rst_b_r;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] pins_s;
    logic [7:0] data_s;
    logic xt_s, xa1_s, xa0_s, bs1_s, bs2_s, pl_s, wr_n_s, oe_n_s;
    pnpp_sync #(.W(8)) u_sync_ctl (
        .clk(CLOCK),
        .rst_n(rst_n),
        .d({CRYSTAL_INPUT_STROBE, LOAD_SELECT_HI, LOAD_SELECT_LO, BYTE_SELECT_ONE,
            BYTE_SELECT_TWO, PAGE_LOAD_STROBE, ~WRITE_N, ~OUTPUT_ENABLE_N}),
        .q(pins_s)
    );
    pnpp_sync #(.W(8)) u_sync_dat (
        .clk(CLOCK),
        .rst_n(rst_n),
        .d(DATA_I),
        .q(data_s)
    );
    assign {xt_s, xa1_s, xa0_s, bs1_s, bs2_s, pl_s} = pins_s[7:2];
    assign wr_n_s = ~pins_s[1];
    assign oe_n_s = ~pins_s[0];

    logic xt_d_r, pl_d_r, wr_d_r;
    logic xt_rise, pl_rise, wr_fall;
    assign xt_rise = xt_s && !xt_d_r;
    assign pl_rise = pl_s && !pl_d_r;
    assign wr_fall = !wr_n_s && wr_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Loads pass a two-entry buffer so a load during a busy write is held.
    logic ld_valid, ld_ready;
    logic [11:0] ld_word;
    logic bsy;
    pnpp_buf2 #(.W(12)) u_ldbuf (
        .clk(CLOCK),
        .rst_n(rst_n),
        .in_valid(xt_rise),
        .in_ready(),
        .in_data({bs1_s, xa1_s, xa0_s, 1'b0, data_s}),
        .out_valid(ld_valid),
        .out_ready(ld_ready),
        .out_data(ld_word)
    );
    assign ld_ready = !bsy;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] cmd_r, cmd_nxt, alo_r, alo_nxt, ahi_r, ahi_nxt, dlo_r, dlo_nxt;
    logic [7:0] dhi_r, dhi_nxt;
    logic wen_r, wen_nxt;
    logic [15:0] addr;
    logic take;
    assign addr = {ahi_r, alo_r};
    assign take = ld_valid && ld_ready;

    always_comb begin
        cmd_nxt = cmd_r;
        alo_nxt = alo_r;
        ahi_nxt = ahi_r;
        dlo_nxt = dlo_r;
        dhi_nxt = dhi_r;
        wen_nxt = wen_r;
        if (take) begin
            unique case (ld_word[10:9])
                PNPP_LD_ADDR: begin
                    if (ld_word[11]) begin
                        ahi_nxt = ld_word[7:0];
                    end else begin
                        alo_nxt = ld_word[7:0];
                    end
                end
                PNPP_LD_DATA: begin
                    if (ld_word[11]) begin
                        dhi_nxt = ld_word[7:0];
                    end else begin
                        dlo_nxt = ld_word[7:0];
                    end
                end
                PNPP_LD_CMD: begin
                    cmd_nxt = ld_word[7:0];
                    wen_nxt = (ld_word[7:0] != PNPP_CMD_NOP);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= PNPP_CMD_NOP;
            alo_r <= 8'h00;
            ahi_r <= 8'h00;
            dlo_r <= PNPP_ERASED;
            dhi_r <= PNPP_ERASED;
            wen_r <= 1'b0;
            xt_d_r <= 1'b0;
            pl_d_r <= 1'b0;
            wr_d_r <= 1'b1;
        end else begin
            cmd_r <= cmd_nxt;
            alo_r <= alo_nxt;
            ahi_r <= ahi_nxt;
            dlo_r <= dlo_nxt;
            dhi_r <= dhi_nxt;
            wen_r <= wen_nxt;
            xt_d_r <= xt_s;
            pl_d_r <= pl_s;
            wr_d_r <= wr_n_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memories and page buffers; writes land when the busy time ends.
    logic [15:0] flash_m [FLASH_WORDS];
    logic [15:0] fpage_m [PAGE_WORDS];
    logic [7:0] ee_m [EE_BYTES];
    logic [7:0] epage_m [EE_PAGE];
    logic [7:0] lfuse_r, hfuse_r, efuse_r, lock_r;
    logic [7:0] lfuse_nxt, hfuse_nxt, efuse_nxt, lock_nxt;
    pnpp_state_e st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [7:0] op_r, op_nxt;
    logic [1:0] fsel_r, fsel_nxt;
    logic [FAW-1:0] fbase_r, fbase_nxt;
    logic [EAW-1:0] ebase_r, ebase_nxt;
    logic done;
    assign bsy = (st_r != PNPP_IDLE);
    assign done = (st_r == PNPP_BUSY) && (cnt_r == '0);

    function automatic logic [FAW-1:0] flash_page(input logic [15:0] a);
        flash_page = {a[FAW-1:PWW], PWW'(0)};
    endfunction

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        fsel_nxt = fsel_r;
        fbase_nxt = fbase_r;
        ebase_nxt = ebase_r;
        lfuse_nxt = lfuse_r;
        hfuse_nxt = hfuse_r;
        efuse_nxt = efuse_r;
        lock_nxt = lock_r;
        unique case (st_r)
            PNPP_IDLE: begin
                if (wr_fall && wen_r) begin
                    st_nxt = PNPP_BUSY;
                    op_nxt = cmd_r;
                    fsel_nxt = {bs2_s, bs1_s};
                    fbase_nxt = flash_page(addr);
                    ebase_nxt = {addr[EAW-1:EPW], EPW'(0)};
                    cnt_nxt = (cmd_r == PNPP_CMD_ERASE) ? ERASE_LEN : PROG_LEN;
                end
            end
            PNPP_BUSY: begin
                cnt_nxt = cnt_r - CW'(1);
                if (done) begin
                    st_nxt = PNPP_IDLE;
                    if (op_r == PNPP_CMD_WR_FUSE) begin
                        unique case (fsel_r)
                            2'h0: lfuse_nxt = dlo_r;
                            2'h1: hfuse_nxt = dlo_r;
                            2'h2: efuse_nxt = dlo_r;
                            default: begin
                            end
                        endcase
                    end else if (op_r == PNPP_CMD_WR_LOCK) begin
                        lock_nxt = lock_r & (dlo_r | ((lock_r[1:0] == 2'h0) ?
                                   PNPP_LOCK_BOOT_MASK : 8'h00));
                    end else if (op_r == PNPP_CMD_ERASE) begin
                        lock_nxt = PNPP_ERASED;
                    end
                end
            end
            default: st_nxt = PNPP_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= PNPP_IDLE;
            cnt_r <= '0;
            op_r <= PNPP_CMD_NOP;
            fsel_r <= 2'h0;
            fbase_r <= '0;
            ebase_r <= '0;
            lfuse_r <= LFUSE_RST;
            hfuse_r <= HFUSE_RST;
            efuse_r <= EFUSE_RST;
            lock_r <= PNPP_ERASED;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            fsel_r <= fsel_nxt;
            fbase_r <= fbase_nxt;
            ebase_r <= ebase_nxt;
            lfuse_r <= lfuse_nxt;
            hfuse_r <= hfuse_nxt;
            efuse_r <= efuse_nxt;
            lock_r <= lock_nxt;
        end
    end

    // Arrays have no reset; contents are the non-volatile image.
    always_ff @(posedge CLOCK) begin
        if (pl_rise && !bsy && wen_r) begin
            fpage_m[addr[PWW-1:0]] <= {dhi_r, dlo_r};
            epage_m[addr[EPW-1:0]] <= dlo_r;
        end
        if (done) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                if (op_r == PNPP_CMD_WR_FLASH) begin
                    flash_m[fbase_r + FAW'(i)] <= fpage_m[i];
                end
            end
            for (int j = 0; j < EE_PAGE; j++) begin
                if (op_r == PNPP_CMD_WR_EE) begin
                    ee_m[ebase_r + EAW'(j)] <= epage_m[j];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] rd_byte, dout_r, dout_nxt;
    logic drv;
    logic [15:0] fword;
    assign fword = flash_m[addr[FAW-1:0]];

    always_comb begin
        rd_byte = PNPP_ERASED;
        drv = !oe_n_s;
        unique case (cmd_r)
            PNPP_CMD_RD_FLASH: rd_byte = bs1_s ? fword[15:8] : fword[7:0];
            PNPP_CMD_RD_EE: rd_byte = ee_m[addr[EAW-1:0]];
            PNPP_CMD_RD_FUSE: begin
                unique case ({bs2_s, bs1_s})
                    PNPP_SEL_LFUSE: rd_byte = lfuse_r;
                    PNPP_SEL_HFUSE: rd_byte = hfuse_r;
                    PNPP_SEL_EFUSE: rd_byte = efuse_r;
                    PNPP_SEL_LOCK: rd_byte = lock_r;
                endcase
            end
            PNPP_CMD_RD_SIG: begin
                if (bs1_s) begin
                    rd_byte = (alo_r == PNPP_CAL_ADDR) ? CAL_BYTE : PNPP_ERASED;
                end else if (alo_r == 8'h00) begin
                    rd_byte = SIG0;
                end else if (alo_r == 8'h01) begin
                    rd_byte = SIG1;
                end else if (alo_r == PNPP_SIG_MAX) begin
                    rd_byte = SIG2;
                end
            end
            default: drv = 1'b0;
        endcase
        dout_nxt = drv ? rd_byte : dout_r;
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 8'h00;
            DATA_O <= 8'h00;
            DATA_OE_N <= 8'hFF;
            READY_BUSY_PIN <= 1'b1;
        end else begin
            dout_r <= dout_nxt;
            DATA_O <= dout_nxt;
            DATA_OE_N <= drv ? 8'h00 : 8'hFF;
            READY_BUSY_PIN <= !bsy && !(st_nxt != PNPP_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ready low within one microsecond
    property p_rdy_fall;
        @(posedge CLOCK) disable iff (!rst_n)
        (wr_fall && wen_r && !bsy) |=> ##[0:2] !READY_BUSY_PIN;
    endproperty
    a_rdy_fall: assert property (p_rdy_fall) else $error("ready not low");

    property p_nop;
        @(posedge CLOCK) disable iff (!rst_n)
        (take && ld_word[10:9] == PNPP_LD_CMD && ld_word[7:0] == PNPP_CMD_NOP) |=> !wen_r;
    endproperty
    a_nop: assert property (p_nop) else $error("nop left writes on");

    // lock bits never rise except after erase
    property p_lock;
        @(posedge CLOCK) disable iff (!rst_n)
        (op_r != PNPP_CMD_ERASE) |=> ((lock_r & ~$past(lock_r)) == 8'h00);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit released");

    property p_busy_pin;
        @(posedge CLOCK) disable iff (!rst_n)
        bsy |-> !READY_BUSY_PIN;
    endproperty
    a_busy_pin: assert property (p_busy_pin) else $error("ready high while busy");

    // raising output enable releases the bus
    property p_oe_off;
        @(posedge CLOCK) disable iff (!rst_n)
        !drv |=> (DATA_OE_N == 8'hFF);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven without read");

    // ready returns once the timed write ends
    sequence s_finish;
        done;
    endsequence
    sequence s_ready_back;
        ##1 (READY_BUSY_PIN || bsy);
    endsequence
    property p_ready_back;
        @(posedge CLOCK) disable iff (!rst_n)
        s_finish |=> s_ready_back;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not restored");
endmodule

// File: pnpp_prog.sv
`timescale 1ns/100ps
module pnpp_prog import pnpp_pkg::*; (
    input wire logic clk,
    input wire logic rdy,
    input wire logic [7:0] dout,
    input wire logic [7:0] doe_n,
    output logic xtal,
    output logic xa1,
    output logic xa0,
    output logic bs1,
    output logic bs2,
    output logic page_load_strobe,
    output logic wr_n,
    output logic oe_n,
    output logic [7:0] bus
);
    logic [7:0] pd;
    logic [7:0] last;
    initial begin
        {xtal, xa1, xa0, bs1, bs2, page_load_strobe} = '0;
        wr_n = 1'b1;
        oe_n = 1'b1;
        pd = 8'h00;
        last = 8'h00;
    end
    // released while reading
    // Undriven bits show the inverse of their last level, so stale data cannot match.
    always_comb bus = (~doe_n & dout) | (doe_n & (oe_n ? pd : ~last));
    always @(posedge clk) last <= bus;
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic load(input logic [1:0] xa, input logic b1, input logic [7:0] d);
        {xa1, xa0} = xa;
        bs1 = b1;
        pd = d;
        step(4);
        xtal = 1'b1;
        step(5);
        xtal = 1'b0;
        step(8);
    endtask
    // latch with byte select one high
    task automatic page();
        bs1 = 1'b1;
        step(4);
        page_load_strobe = 1'b1;
        step(5);
        page_load_strobe = 1'b0;
        step(8);
    endtask
    task automatic write(input logic b1, input logic b2, output int fall, output int rise);
        {bs1, bs2} = {b1, b2};
        step(4);
        wr_n = 1'b0;
        fall = -1;
        rise = 0;
        while (rise < 5000 && (fall < 0 ? rise < 120 : !rdy)) begin
            step(1);
            rise++;
            if (rise == 5) wr_n = 1'b1;
            if (fall < 0 && !rdy) fall = rise;
        end
        wr_n = 1'b1;
        {bs1, bs2} = 2'b00;
        step(8);
    endtask
    task automatic read(input logic b1, input logic b2, output logic [7:0] v);
        {bs1, bs2} = {b1, b2};
        step(4);
        oe_n = 1'b0;
        step(12);
        v = bus;
        oe_n = 1'b1;
        step(8);
    endtask
endmodule

// File: pnpp_sync.sv
`timescale 1ns/100ps
module pnpp_sync import pnpp_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_nxt;

    // A change is accepted only once the second and third stage agree.
    always_comb begin
        q_nxt = q;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= q_nxt;
        end
    end
endmodule

// File: test_parallel_nvm_programming_port.sv
`timescale 1ns/100ps
module test_parallel_nvm_programming_port import pnpp_pkg::*; ();
    localparam int PROG = 60;
    localparam int ERASE = 120;
    // Identification values are arbitrary.
    localparam logic [7:0] SIGS [4] = '{8'h3C, 8'h96, 8'h4B, 8'h6D};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xtal, xa1, xa0, bs1, bs2, page_load_strobe, wr_n, oe_n, rdy;
    logic [7:0] bus, dout, doe_n, v, lk;
    logic [7:0] fw [4][2];
    logic [7:0] ew [4];
    logic [7:0] fz [3];
    logic [7:0] ld [4] = '{8'hFE, 8'hFD, 8'hC3, 8'hFF};
    logic [31:0] seed = 32'hB40332E7;
    int n_fail = 0;
    int checked = 0;
    int f, r;
    always #5 clk = ~clk;
    pnpp_port #(.PROG_CYC(PROG), .ERASE_CYC(ERASE), .SIG0(SIGS[0]), .SIG1(SIGS[1]),
        .SIG2(SIGS[2]), .CAL_BYTE(SIGS[3])) dut_u (.CLOCK(clk), .RESETN(rst_n),
        .CRYSTAL_INPUT_STROBE(xtal), .LOAD_SELECT_HI(xa1), .LOAD_SELECT_LO(xa0),
        .BYTE_SELECT_ONE(bs1), .BYTE_SELECT_TWO(bs2), .PAGE_LOAD_STROBE(page_load_strobe),
        .WRITE_N(wr_n), .OUTPUT_ENABLE_N(oe_n), .DATA_I(bus), .DATA_O(dout),
        .DATA_OE_N(doe_n), .READY_BUSY_PIN(rdy));
    pnpp_prog prog_u (.clk(clk), .rdy(rdy), .dout(dout), .doe_n(doe_n), .xtal(xtal),
        .xa1(xa1), .xa0(xa0), .bs1(bs1), .bs2(bs2), .page_load_strobe(page_load_strobe), .wr_n(wr_n),
        .oe_n(oe_n), .bus(bus));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Zero data bits program; boot bits stay put once both main bits are programmed.
    function automatic logic [7:0] lockx(input logic [7:0] old, input logic [7:0] d);
        return old & (old[1:0] == 2'b00 ? (d | PNPP_LOCK_BOOT_MASK) : d);
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chkw(input string nm, input int span);
        chk({nm, " fall"}, 8'(f > 0 && f <= PNPP_WLRL_CYC), 8'h01);
        chk({nm, " span"}, 8'(r >= f + span - 1 && r <= f + span + 12), 8'h01);
    endtask
    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (8) @(negedge clk);
        chk("reset oe", doe_n, 8'hFF);
        chk("reset ready", {7'h0, rdy}, 8'h01);
        rst_n = 1'b1;
        prog_u.step(10);
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_WR_FLASH);
        for (int w = 0; w < 4; w++) begin
            fw[w][0] = rnd();
            fw[w][1] = rnd();
            prog_u.load(PNPP_LD_ADDR, 1'b0, 8'h10 + 8'(w));
            prog_u.load(PNPP_LD_DATA, 1'b0, fw[w][0]);
            prog_u.load(PNPP_LD_DATA, 1'b1, fw[w][1]);
            prog_u.page();
        end
        prog_u.load(PNPP_LD_ADDR, 1'b1, 8'h00);
        prog_u.write(1'b0, 1'b0, f, r);
        chkw("flash", PROG);
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_NOP);
        prog_u.write(1'b0, 1'b0, f, r);
        chk("nop write", 8'(f < 0), 8'h01);
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_RD_FLASH);
        prog_u.load(PNPP_LD_ADDR, 1'b1, 8'h00);
        for (int w = 0; w < 4; w++) begin
            prog_u.load(PNPP_LD_ADDR, 1'b0, 8'h10 + 8'(w));
            prog_u.read(1'b0, 1'b0, v);
            chk("flash lo", v, fw[w][0]);
            prog_u.read(1'b1, 1'b0, v);
            chk("flash hi", v, fw[w][1]);
        end
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_WR_EE);
        prog_u.load(PNPP_LD_ADDR, 1'b1, 8'h01);
        for (int i = 0; i < 4; i++) begin
            ew[i] = rnd();
            prog_u.load(PNPP_LD_ADDR, 1'b0, 8'h20 + 8'(i));
            prog_u.load(PNPP_LD_DATA, 1'b0, ew[i]);
            prog_u.page();
        end
        // Two loads issued while busy must wait in the buffer and take effect afterwards.
        fork
            prog_u.write(1'b0, 1'b0, f, r);
            begin
                prog_u.step(20);
                prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_RD_EE);
                prog_u.load(PNPP_LD_ADDR, 1'b0, 8'h22);
            end
        join
        chkw("eeprom", PROG);
        prog_u.read(1'b0, 1'b0, v);
        chk("eeprom queued", v, ew[2]);
        prog_u.load(PNPP_LD_ADDR, 1'b0, 8'h20);
        prog_u.read(1'b0, 1'b0, v);
        chk("eeprom first", v, ew[0]);
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_WR_FUSE);
        for (int k = 0; k < 3; k++) begin
            fz[k] = rnd();
            prog_u.load(PNPP_LD_DATA, 1'b0, fz[k]);
            prog_u.write(k == 1, k == 2, f, r);
        end
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_RD_FUSE);
        prog_u.read(1'b0, 1'b0, v);
        chk("fuse low", v, fz[0]);
        prog_u.read(1'b1, 1'b1, v);
        chk("fuse high", v, fz[1]);
        prog_u.read(1'b0, 1'b1, v);
        chk("fuse ext", v, fz[2]);
        lk = 8'hFF;
        for (int k = 0; k < 4; k++) begin
            prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_WR_LOCK);
            prog_u.load(PNPP_LD_DATA, 1'b0, ld[k]);
            prog_u.write(1'b0, 1'b0, f, r);
            lk = lockx(lk, ld[k]);
            prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_RD_FUSE);
            prog_u.read(1'b1, 1'b0, v);
            chk("lock", v, lk);
        end
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_ERASE);
        prog_u.write(1'b0, 1'b0, f, r);
        chkw("erase", ERASE);
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_RD_FUSE);
        prog_u.read(1'b1, 1'b0, v);
        chk("lock erased", v, 8'hFF);
        prog_u.load(PNPP_LD_CMD, 1'b0, PNPP_CMD_RD_SIG);
        for (int a = 0; a < 3; a++) begin
            prog_u.load(PNPP_LD_ADDR, 1'b0, 8'(a));
            prog_u.read(1'b0, 1'b0, v);
            chk("signature", v, SIGS[a]);
        end
        prog_u.load(PNPP_LD_ADDR, 1'b0, PNPP_CAL_ADDR);
        prog_u.read(1'b1, 1'b0, v);
        chk("calibration", v, SIGS[3]);
        summarize();
    end
endmodule
